// ### core/sscs_pkg.sv
// Package: register map, field layout and reset values of the sync serial channel
package sscs_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_BAUD   = 8'h04;
    localparam logic [7:0] OFF_TXBUF  = 8'h08;
    localparam logic [7:0] OFF_RXBUF  = 8'h0c;
    localparam logic [7:0] OFF_SSCTRL = 8'h10;
    localparam logic [7:0] OFF_STATUS = 8'h14;
    localparam logic [7:0] OFF_ISTAT  = 8'h18;
    localparam logic [7:0] OFF_ICLR   = 8'h1c;
    localparam logic [7:0] OFF_IEN    = 8'h20;

    // Flow control settings
    localparam logic [1:0] FLOW_NONE = 2'h0;
    localparam logic [1:0] FLOW_CTS  = 2'h1;
    localparam logic [1:0] FLOW_RTS  = 2'h2;

    // Shared serial control fields
    localparam int SSC_PIN_SEL = 4;
    localparam int SSC_DUAL    = 5;

    // Interrupt status bits
    localparam int IRQ_TX  = 0;
    localparam int IRQ_RX  = 1;
    localparam int IRQ_OVR = 2;
    localparam int IRQ_W   = 3;

    // Status register bits
    localparam int ST_TBUF_FULL = 0;
    localparam int ST_RX_FULL   = 1;
    localparam int ST_OVERRUN   = 2;
    localparam int ST_BUSY      = 3;
    localparam int ST_FLOW_PIN  = 4;

    // Reset values
    localparam logic [7:0] CTRL_RST   = 8'h00;
    localparam logic [7:0] BAUD_RST   = 8'hff;
    localparam logic [7:0] SSCTRL_RST = 8'h00;

    // Index of the last bit in a frame
    localparam logic [2:0] LAST_BIT = 3'h7;

    // Control register layout, bit 7 down to bit 0
    typedef struct packed {
        logic       gpio_oe;
        logic       gpio_out;
        logic       tx_irq_done;
        logic       ext_clk;
        logic [1:0] flow;
        logic       rx_en;
        logic       tx_en;
    } sscs_ctrl_s;
endpackage

// ### core/sscs_sync.sv
// Two flip-flop synchroniser for inputs from outside the pclk domain
`timescale 1ns/1ps
`default_nettype none
module sscs_sync #(
    parameter int W = 1
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule // sscs_sync
`default_nettype wire

// ### core/sscs_top.sv
// Sync serial channel: APB registers, shifter, CTS/RTS flow control, dual clock pins
//
// Notes on behaviour
// R1: In dual-pin mode, clock appears on only one of two pins, per pin select.
// R2: Pin select is bit 4 of shared serial control; toggling moves the clock.
// R3: Host toggles pin select on each transmit interrupt, then writes next byte.
// R4: Host sets transmit enable, then writes first byte; secondary pin if selected.
// R5: With CTS flow, clock starts and transmit begins once CTS is seen low.
// R6: CTS is sampled only at byte start; a byte in flight always completes (here clearing transmit enable aborts it mid-byte).
// R7: After stopping for CTS high, clocking resumes when CTS returns low.
// R8: With RTS flow, RTS is driven low whenever the receiver is ready.
// R9: RTS goes high on the first falling clock edge of a reception.
// R10: RTS goes low at the eighth bit's rising edge, whether or not buffer read.
// R11: Flow is CTS, RTS or none; with none the flow pin is general I/O.
// R12: Host sets transmit and receive enable, writes dummy byte; RTS then goes low.
// R13: Host writes one more dummy byte for each further byte to receive.
// R14: Overrun flagged when a byte completes before the previous one was read.
// R15: On overrun the newest byte stays in the buffer and no receive event.
// R16: Overrun sets the overrun error flag to one.
// R17: Host recovers from overrun by reinit and resend; timeouts are software's.
// R18: Each written byte moves into the shift register before shifting out.
// R19: In dual-pin mode the unselected clock pin stays at its idle level.
`timescale 1ns/1ps
`default_nettype none
module sscs_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    output var  logic        txd,
    input  wire logic        rxd,
    output logic             primary_clock_out_pin,
    output logic             secondary_clock_out_pin,
    input  wire logic        ext_clk_in,
    input  wire logic        flow_pin_i,
    output logic             flow_pin_o,
    output logic             flow_pin_oe
);
    typedef enum logic {SSCS_IDLE, SSCS_RUN} sscs_state_e;

    // Address decode used for the error answer only; the read mux decodes paddr in its own case
    function automatic logic sscs_addr_ok(input logic [7:0] a);
        return a == sscs_pkg::OFF_CTRL   || a == sscs_pkg::OFF_BAUD  ||
               a == sscs_pkg::OFF_TXBUF  || a == sscs_pkg::OFF_RXBUF ||
               a == sscs_pkg::OFF_SSCTRL || a == sscs_pkg::OFF_STATUS ||
               a == sscs_pkg::OFF_ISTAT  || a == sscs_pkg::OFF_ICLR  ||
               a == sscs_pkg::OFF_IEN;
    endfunction

    sscs_pkg::sscs_ctrl_s          ctrl_q;
    logic [7:0]                    baud_q;
    logic [7:0]                    ssctrl_q;
    logic [7:0]                    tbuf_q;
    logic                          tbuf_full_q;
    logic [7:0]                    rbuf_q;
    logic                          rx_full_q;
    logic                          ovr_q;
    logic [sscs_pkg::IRQ_W-1:0]    istat_q;
    logic [sscs_pkg::IRQ_W-1:0]    ien_q;
    sscs_state_e                   state_q;
    logic [7:0]                    tx_sh_q;
    logic [7:0]                    rx_sh_q;
    logic [2:0]                    bit_q;
    logic                          first_q;
    logic                          sel_q;
    logic [7:0]                    div_q;
    logic                          clk_q;
    logic                          ext_prev_q;
    logic                          rts_q;

    // Pin inputs pass the synchroniser before any logic reads them
    logic [2:0] pins_s;
    sscs_sync #(.W(3)) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       ({ext_clk_in, rxd, flow_pin_i}),
        .q       (pins_s)
    );
    wire ext_s  = pins_s[2];
    wire rxd_s  = pins_s[1];
    wire flow_s = pins_s[0];

    // APB decode; zero wait state, read data latched in the setup cycle
    wire acc     = psel & penable;
    wire wr      = acc & pwrite;
    wire rd      = acc & ~pwrite;
    wire setup   = psel & ~penable;
    wire wr_ctrl = wr & (paddr == sscs_pkg::OFF_CTRL);
    wire wr_baud = wr & (paddr == sscs_pkg::OFF_BAUD);
    wire wr_tbuf = wr & (paddr == sscs_pkg::OFF_TXBUF);
    wire wr_ssc  = wr & (paddr == sscs_pkg::OFF_SSCTRL);
    wire wr_iclr = wr & (paddr == sscs_pkg::OFF_ICLR);
    wire wr_ien  = wr & (paddr == sscs_pkg::OFF_IEN);
    wire rd_rx   = rd & (paddr == sscs_pkg::OFF_RXBUF);
    assign pready  = 1'b1;
    assign pslverr = acc & ~sscs_addr_ok(paddr);

    // Clock edges: internal divider or sampled external link clock
    wire run      = state_q == SSCS_RUN;
    wire tick     = div_q == baud_q;
    wire ext_rise = ext_s & ~ext_prev_q;
    wire ext_fall = ~ext_s & ext_prev_q;
    wire sh_fall  = run & (ctrl_q.ext_clk ? ext_fall : (tick & clk_q));
    wire sh_rise  = run & (ctrl_q.ext_clk ? ext_rise : (tick & ~clk_q));
    wire done     = sh_rise & (bit_q == sscs_pkg::LAST_BIT);

    // CTS only gates the start of a byte, never a byte in flight
    wire cts_ok = (ctrl_q.flow != sscs_pkg::FLOW_CTS) | ~flow_s; // R5 R6 R7
    wire start  = ~run & tbuf_full_q & ctrl_q.tx_en & cts_ok;  // R5 R7
    wire [7:0] rx_byte = {rxd_s, rx_sh_q[7:1]};
    wire ovr_evt = done & ctrl_q.rx_en & rx_full_q & ~rd_rx;  // R14
    wire rx_evt  = done & ctrl_q.rx_en & ~ovr_evt;
    wire tx_evt  = ctrl_q.tx_irq_done ? done : start;

    // Control registers written by software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q   <= sscs_pkg::CTRL_RST;
            baud_q   <= sscs_pkg::BAUD_RST;
            ssctrl_q <= sscs_pkg::SSCTRL_RST;
            ien_q    <= '0;
        end else begin
            if (wr_ctrl)
                ctrl_q <= pwdata[7:0];
            if (wr_baud)
                baud_q <= pwdata[7:0];
            if (wr_ssc)
                ssctrl_q <= pwdata[7:0]; // R2
            if (wr_ien)
                ien_q <= pwdata[sscs_pkg::IRQ_W-1:0];
        end
    end

    // Transmit buffer; a write in the same cycle as a load wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tbuf_q      <= 8'h00;
            tbuf_full_q <= 1'b0;
        end else begin
            if (wr_tbuf)
                tbuf_q <= pwdata[7:0];
            if (wr_tbuf)
                tbuf_full_q <= 1'b1;
            else if (start)
                tbuf_full_q <= 1'b0; // R18
        end
    end

    // Receive buffer and overrun flag; clearing rx enable clears the overrun flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rbuf_q    <= 8'h00;
            rx_full_q <= 1'b0;
            ovr_q     <= 1'b0;
        end else begin
            if (done & ctrl_q.rx_en)
                rbuf_q <= rx_byte; // R15
            if (rx_evt)
                rx_full_q <= 1'b1;
            else if (rd_rx)
                rx_full_q <= 1'b0;
            if (ovr_evt)
                ovr_q <= 1'b1; // R16
            else if (!ctrl_q.rx_en)
                ovr_q <= 1'b0;
        end
    end

    // Sticky interrupt status; a new event beats a clear in the same cycle
    logic [sscs_pkg::IRQ_W-1:0] ev;
    assign ev[sscs_pkg::IRQ_TX]  = tx_evt;
    assign ev[sscs_pkg::IRQ_RX]  = rx_evt; // R15
    assign ev[sscs_pkg::IRQ_OVR] = ovr_evt; // R14
    wire [sscs_pkg::IRQ_W-1:0] clr = wr_iclr ? pwdata[sscs_pkg::IRQ_W-1:0] : '0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            istat_q <= '0;
        else
            istat_q <= (istat_q & ~clr) | ev;
    end
    assign irq = |(istat_q & ien_q);

    // Byte sequencer: one byte per start, then back to idle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= SSCS_IDLE;
        end else begin
            unique case (state_q)
                SSCS_IDLE: begin
                    if (start)
                        state_q <= SSCS_RUN;
                end
                SSCS_RUN: begin
                    if (done | ~ctrl_q.tx_en)
                        state_q <= SSCS_IDLE; // R6
                end
            endcase
        end
    end

    // Shift registers: data out on falling edge, sampled on rising edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_sh_q <= 8'h00;
            rx_sh_q <= 8'h00;
            bit_q   <= 3'h0;
            first_q <= 1'b0;
            txd     <= 1'b1;
        end else begin
            if (start) begin
                tx_sh_q <= tbuf_q; // R18
                bit_q   <= 3'h0;
                first_q <= 1'b1;
            end else begin
                if (sh_fall) begin
                    txd     <= tx_sh_q[0];
                    first_q <= 1'b0;
                end
                if (sh_rise) begin
                    tx_sh_q <= tx_sh_q >> 1;
                    rx_sh_q <= rx_byte;
                    bit_q   <= bit_q + 3'h1;
                end
            end
        end
    end

    // Internal clock divider; the clock only runs while a byte is in flight
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= 8'h00;
            clk_q <= 1'b1;
        end else if (run & ~ctrl_q.ext_clk & ~done) begin
            div_q <= tick ? 8'h00 : div_q + 8'h01;
            if (tick)
                clk_q <= ~clk_q; // R5
        end else begin
            div_q <= 8'h00;
            clk_q <= 1'b1;
        end
    end

    // External clock edge detector, reads only the synchronised copy
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            ext_prev_q <= 1'b1;
        else
            ext_prev_q <= ext_s;
    end

    // Pin select is frozen per byte, so toggling it early cannot cut a byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            sel_q <= 1'b0;
        else if (start)
            sel_q <= ssctrl_q[sscs_pkg::SSC_PIN_SEL]; // R1 R3 R4
    end

    // Clock pins; unselected pin idles high in dual-pin mode
    wire dual  = ssctrl_q[sscs_pkg::SSC_DUAL];
    wire clk_v = ctrl_q.ext_clk ? 1'b1 : clk_q;
    assign primary_clock_out_pin   = (dual & sel_q) ? 1'b1 : clk_v; // R1 R19
    assign secondary_clock_out_pin = (dual & sel_q) ? clk_v : 1'b1; // R1 R19

    // RTS: low when ready, high at first falling edge, low at last bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            rts_q <= 1'b1;
        else if (!(ctrl_q.rx_en & ctrl_q.tx_en))
            rts_q <= 1'b1;
        else if (start)
            rts_q <= 1'b0; // R8 R12
        else if (sh_fall & first_q)
            rts_q <= 1'b1; // R9
        else if (done)
            rts_q <= 1'b0; // R10
    end

    // Flow pin: CTS input, RTS output, or general I/O
    wire is_rts = ctrl_q.flow == sscs_pkg::FLOW_RTS;
    wire is_gp  = ctrl_q.flow == sscs_pkg::FLOW_NONE;
    assign flow_pin_o  = is_rts ? rts_q : ctrl_q.gpio_out; // R8 R11
    assign flow_pin_oe = is_rts | (is_gp & ctrl_q.gpio_oe); // R11

    // Read mux
    logic [7:0] stat;
    assign stat = {3'h0, flow_s, run, ovr_q, rx_full_q, tbuf_full_q};
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (paddr)
            sscs_pkg::OFF_CTRL:   rd_mux[7:0] = ctrl_q;
            sscs_pkg::OFF_BAUD:   rd_mux[7:0] = baud_q;
            sscs_pkg::OFF_RXBUF:  rd_mux[7:0] = rbuf_q;
            sscs_pkg::OFF_SSCTRL: rd_mux[7:0] = ssctrl_q;
            sscs_pkg::OFF_STATUS: rd_mux[7:0] = stat;
            sscs_pkg::OFF_ISTAT:  rd_mux[sscs_pkg::IRQ_W-1:0] = istat_q;
            sscs_pkg::OFF_IEN:    rd_mux[sscs_pkg::IRQ_W-1:0] = ien_q;
            default:              rd_mux = 32'h0000_0000;
        endcase
    end

    // Read data captured in setup so it stands through the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (setup)
            prdata <= rd_mux;
    end
endmodule // sscs_top
`default_nettype wire

// ### tb/sscs_chk_sva.sv
// Checker: port-level timing properties of the sync serial channel
`timescale 1ns/1ps
`default_nettype none
module sscs_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        txd,
    input wire logic        primary_clock_out_pin,
    input wire logic        secondary_clock_out_pin,
    input wire logic        flow_pin_o,
    input wire logic        flow_pin_oe
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Software writes move outputs directly, so serial edge rules skip the cycle after one
    logic wr_now;
    assign wr_now = psel && penable && pwrite;

    // A serial edge: the selected pin fell, or both pins idle while an outside clock runs
    sequence link_edge;
        $fell(primary_clock_out_pin) || $fell(secondary_clock_out_pin)
            || (primary_clock_out_pin && secondary_clock_out_pin);
    endsequence

    chk_zero_wait: assert property (psel && penable |-> pready)
        else $error("pready low in access phase");
    chk_err_access: assert property (pslverr |-> psel && penable)
        else $error("pslverr outside access phase");
    chk_err_map: assert property (psel && penable && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 8'h20))
        else $error("pslverr disagrees with address map");
    chk_one_clock: assert property (primary_clock_out_pin || secondary_clock_out_pin)
        else $error("both clock pins active together");
    chk_rts_rise: assert property (flow_pin_oe && $rose(flow_pin_o) && !$past(wr_now) |-> link_edge)
        else $error("request line rose away from a falling clock edge");
    chk_txd_edge: assert property ($changed(txd) && !$past(wr_now) |-> link_edge)
        else $error("txd changed away from a falling clock edge");
    chk_rdata_hold: assert property (psel && penable && !pwrite |=> $stable(prdata))
        else $error("prdata reloaded in access phase");
    chk_reset_idle: assert property (disable iff (1'b0) $rose(presetn)
        |-> txd && primary_clock_out_pin && secondary_clock_out_pin && !flow_pin_oe && prdata == 32'h0)
        else $error("outputs not idle after reset");

    cov_secondary: cover property ($fell(secondary_clock_out_pin));
    cov_rts_rise: cover property (flow_pin_oe && $rose(flow_pin_o));
    cov_slverr: cover property (pslverr);
endmodule // sscs_chk

bind sscs_top sscs_chk u_sscs_chk (.*);
`default_nettype wire

// ### tb/sscs_peer.sv
// Partner model: an external serial chip hanging on one clock line
`timescale 1ns/1ps
`default_nettype none
module sscs_peer #(
    parameter int HOLD_NS = 80
) (
    input  wire logic       sclk,
    input  wire logic       arm,
    input  wire logic       txd,
    input  wire logic [7:0] tx_byte,
    output var  logic       rxd,
    output var  logic [7:0] got,
    output var  logic [7:0] n_got
);
    logic [7:0] sh;
    logic [2:0] bit_q;
    initial begin
        rxd = 1'b0;
        got = 8'h00;
        n_got = 8'h00;
        sh = 8'h00;
        bit_q = 3'h0;
    end
    // Launch on the falling edge so the bit is settled at the rising one
    always @(negedge sclk) begin
        if (arm) rxd <= tx_byte[bit_q];
    end
    // Capture LSB first; reset-time edges are ignored until armed
    always @(posedge sclk) begin
        if (arm) begin
            sh <= {txd, sh[7:1]};
            bit_q <= bit_q + 3'h1;
            if (bit_q == 3'h7) begin
                got <= {txd, sh[7:1]};
                n_got <= n_got + 8'h01;
            end
        end
    end
    // Hold bit 7 past the receiver's synchronised sample, then let the line go
    always @(posedge sclk) begin
        if (arm && bit_q == 3'h7) begin
            #(HOLD_NS);
            if (sclk)
                rxd <= ~tx_byte[7]; // Undriven line, no pull: show a changed level
        end
    end
endmodule // sscs_peer
`default_nettype wire

// ### tb/tb_top.sv
// Testbench: APB sequences against the sync serial channel and two partner chips
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        pclk = 1'b0;
    logic        presetn, psel, penable, pwrite, ext_clk_in, cts_lvl, ext_run, ext_mode, arm;
    logic [7:0]  paddr, rx_pat, got0, got1, n0, n1;
    logic [31:0] pwdata, prdata, q;
    logic        pready, pslverr, irq, txd, rxd, pcl, scl, flow_pin_o, flow_pin_oe, e;
    int          errors, tests_run, cycles;
    wire         flow_pin_i = flow_pin_oe ? flow_pin_o : cts_lvl; // Follows cts_lvl when undriven
    wire         clk0 = ext_mode ? ext_clk_in : pcl;

    always #10 pclk = ~pclk;
    // Outside clock at 160 ns, unrelated phase, running only inside frames
    initial begin
        ext_clk_in = 1'b1;
        #7;
        forever begin
            #80;
            if (ext_run) ext_clk_in = ~ext_clk_in;
        end
    end

    sscs_top u_sscs_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .txd(txd), .rxd(rxd), .primary_clock_out_pin(pcl), .secondary_clock_out_pin(scl),
        .ext_clk_in(ext_clk_in), .flow_pin_i(flow_pin_i), .flow_pin_o(flow_pin_o), .flow_pin_oe(flow_pin_oe));
    sscs_peer u_sscs_peer (.sclk(clk0), .arm(arm), .txd(txd), .tx_byte(rx_pat), .rxd(rxd), .got(got0), .n_got(n0));
    sscs_peer u_sscs_peer_b (.sclk(scl), .arm(arm), .txd(txd), .tx_byte(8'h00), .rxd(), .got(got1), .n_got(n1));

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    // One APB transfer; holds the request until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50) begin
            @(posedge pclk);
            n++;
        end
        q = prdata;
        e = pslverr;
        if (pready !== 1'b1)
            errors++;
        psel <= 1'b0; penable <= 1'b0;
        // Let one edge pass so a following call never rewrites psel in this time step
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(name, exp, q);
    endtask
    // Poll status until the transmit buffer is empty and the shifter idle, or a bit is set
    task automatic poll(input logic [31:0] mask, input logic [31:0] want);
        int n;
        n = 0;
        q = ~want;
        while ((q & mask) !== want && n < 300) begin
            apb(1'b0, sscs_pkg::OFF_STATUS, 32'h0);
            n++;
        end
        chk("poll_status", want, q & mask);
    endtask
    // One received frame clocked by the outside chip
    task automatic frame(input logic [7:0] pat);
        rx_pat = pat;
        ext_run = 1'b1;
        @(negedge ext_clk_in);
        @(negedge ext_clk_in);
        chk("rts_busy", 32'h1, flow_pin_o);
        repeat (7) @(posedge ext_clk_in);
        ext_run = 1'b0;
        repeat (10) @(posedge pclk);
        chk("rts_done", 32'h0, flow_pin_o);
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // Hang guard
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            give_verdict;
        end
    end

    initial begin
        {psel, penable, pwrite, paddr, pwdata, presetn, ext_run, ext_mode, arm} = '0;
        {cts_lvl, rx_pat, errors, tests_run, cycles} = {1'b1, 8'h00, 32'd0, 32'd0, 32'd0};
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        arm <= 1'b1;
        @(posedge pclk);
        rd_chk("ctrl", sscs_pkg::OFF_CTRL, {24'h0, sscs_pkg::CTRL_RST});
        rd_chk("baud", sscs_pkg::OFF_BAUD, {24'h0, sscs_pkg::BAUD_RST});
        rd_chk("ssctrl", sscs_pkg::OFF_SSCTRL, {24'h0, sscs_pkg::SSCTRL_RST});
        apb(1'b0, 8'h24, 32'h0);
        chk("unmapped_err", 32'h1, e);
        chk("unmapped_data", 32'h0, q);
        $display("test reset_map done");
        // Two chips share txd; the pin is swapped after the first transmit event
        wr(sscs_pkg::OFF_BAUD, 32'h1);
        wr(sscs_pkg::OFF_SSCTRL, 32'h30);
        wr(sscs_pkg::OFF_IEN, 32'h1);
        wr(sscs_pkg::OFF_CTRL, 32'h1);
        wr(sscs_pkg::OFF_TXBUF, 32'ha5);
        for (int n = 0; n < 200 && irq !== 1'b1; n++) @(posedge pclk);
        chk("tx_event", 32'h1, irq);
        wr(sscs_pkg::OFF_SSCTRL, 32'h20);
        wr(sscs_pkg::OFF_ICLR, 32'h1);
        wr(sscs_pkg::OFF_TXBUF, 32'h3c);
        poll(32'h9, 32'h0);
        chk("secondary_byte", 32'ha5, got1);
        chk("primary_byte", 32'h3c, got0);
        chk("secondary_count", 32'h1, n1);
        chk("primary_count", 32'h1, n0);
        $display("test dual_pin done");
        // Clear-to-send gating
        wr(sscs_pkg::OFF_CTRL, 32'h5);
        wr(sscs_pkg::OFF_TXBUF, 32'h96);
        repeat (20) @(posedge pclk);
        rd_chk("cts_held", sscs_pkg::OFF_STATUS, 32'h11);
        cts_lvl <= 1'b0;
        poll(32'h8, 32'h8);
        cts_lvl <= 1'b1;
        wr(sscs_pkg::OFF_TXBUF, 32'h69);
        for (int n = 0; n < 300 && n0 !== 8'h02; n++) @(posedge pclk);
        chk("cts_count", 32'h2, n0);
        repeat (20) @(posedge pclk);
        chk("cts_finish", 32'h96, got0);
        rd_chk("cts_stop", sscs_pkg::OFF_STATUS, 32'h11);
        cts_lvl <= 1'b0;
        poll(32'h9, 32'h0);
        chk("cts_resume", 32'h69, got0);
        $display("test cts done");
        // Request-to-send reception on the outside clock, then an overrun
        ext_mode = 1'b1;
        wr(sscs_pkg::OFF_ICLR, 32'h7);
        wr(sscs_pkg::OFF_IEN, 32'h6);
        wr(sscs_pkg::OFF_CTRL, 32'h1b);
        wr(sscs_pkg::OFF_TXBUF, 32'h0);
        repeat (3) @(posedge pclk);
        chk("rts_ready", 32'h0, flow_pin_o);
        chk("rts_drive", 32'h1, flow_pin_oe);
        frame(8'h5a);
        chk("rx_irq", 32'h1, irq);
        rd_chk("istat_rx", sscs_pkg::OFF_ISTAT, 32'h3);
        rd_chk("rxbuf", sscs_pkg::OFF_RXBUF, 32'h5a);
        wr(sscs_pkg::OFF_TXBUF, 32'h0);
        frame(8'hc3);
        wr(sscs_pkg::OFF_ICLR, 32'h7);
        wr(sscs_pkg::OFF_TXBUF, 32'h0);
        frame(8'he1);
        rd_chk("istat_ovr", sscs_pkg::OFF_ISTAT, 32'h5);
        rd_chk("status_ovr", sscs_pkg::OFF_STATUS, 32'h6);
        rd_chk("rxbuf_new", sscs_pkg::OFF_RXBUF, 32'he1);
        wr(sscs_pkg::OFF_IEN, 32'h0);
        @(posedge pclk);
        chk("irq_masked", 32'h0, irq);
        wr(sscs_pkg::OFF_ICLR, 32'h7);
        rd_chk("istat_clr", sscs_pkg::OFF_ISTAT, 32'h0);
        $display("test rts_overrun done");
        // Flow pin as plain I/O; disabling reception clears the overrun
        ext_mode = 1'b0;
        wr(sscs_pkg::OFF_CTRL, 32'hc0);
        @(posedge pclk);
        chk("gpio_drive", 32'h3, {flow_pin_oe, flow_pin_o});
        wr(sscs_pkg::OFF_CTRL, 32'h0);
        cts_lvl <= 1'b0;
        repeat (4) @(posedge pclk);
        rd_chk("gpio_in", sscs_pkg::OFF_STATUS, 32'h0);
        $display("test gpio done");
        give_verdict;
    end
endmodule // tb_top
`default_nettype wire
